//--- shared/tovi_pkg.sv
// Constants for the timer overflow interrupt block.
// Assumes a 32-bit APB slave with one aligned word per register.
package tovi_pkg;
	// ----------------------------------------
	// Register indices (byte address = 4 * index)
	// ----------------------------------------
	localparam logic [7:0] IDX_TIMER_COUNT = 8'h01;
	localparam logic [7:0] IDX_INTCTL      = 8'h0B;
	localparam logic [7:0] IDX_OPTION      = 8'h81;
	localparam logic [7:0] IDX_PORTA_DIR   = 8'h85;
	localparam logic [7:0] IDX_CTRL        = 8'hC0;
	localparam logic [7:0] IDX_IRQ_STATUS  = 8'hC1;
	localparam logic [7:0] IDX_IRQ_MASK    = 8'hC2;
	localparam int         ADDR_W          = 12;
	// ----------------------------------------
	// Interrupt control bit positions
	// ----------------------------------------
	localparam int BIT_GLOBAL_EN  = 7;
	localparam int BIT_TOVF_EN    = 5;
	localparam int BIT_TOVF_FLAG  = 2;
	// ----------------------------------------
	// Option bit positions
	// ----------------------------------------
	localparam int BIT_PULLUP_DIS = 7;
	localparam int BIT_CLK_SOURCE = 5;
	localparam int BIT_SRC_EDGE   = 4;
	localparam int BIT_PS_ASSIGN  = 3;
	localparam int PS_RATE_MSB    = 2;
	// ----------------------------------------
	// Own control and event bits
	// ----------------------------------------
	localparam int BIT_SLEEP      = 0;
	localparam int EVT_OVERFLOW   = 0;
	localparam int EVT_WD_TICK    = 1;
	localparam int EVT_W          = 2;
	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] RST_TIMER_COUNT = 8'h00;
	localparam logic [7:0] RST_INTCTL      = 8'h00;
	localparam logic [7:0] RST_OPTION      = 8'hFF;
	localparam logic [4:0] RST_PORTA_DIR   = 5'h1F;
	localparam logic [7:0] RST_CTRL        = 8'h00;
	localparam logic [31:0] RD_ZERO        = 32'h0000_0000;
endpackage

//--- core/tovi_prescaler.sv
// Shared prescaler: divides an event stream by 2**rate_exp.
// Assumes the owner clears it whenever its assignment changes.
`timescale 1ns/1ps
module tovi_prescaler #(
	parameter int CNT_W = 8                 // Counter width
) (
	input  wire logic       clk,           // Core clock
	input  wire logic       rst_n,         // Synchronous reset, low
	input  wire logic       clr,           // Clear the count
	input  wire logic       event_in,      // One event to count
	input  wire logic [3:0] rate_exp,      // Divide by 2**rate_exp
	output logic            tick           // One pulse per period
);
	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] mask;

	if (CNT_W < 1 || CNT_W > 15) begin : g_chk
		$error("tovi_prescaler: CNT_W out of range");
	end

	assign mask = CNT_W'(({{CNT_W{1'b0}}, 1'b1} << rate_exp) - 1'b1);
	// A clear restarts the division, so a stale count never leaks a tick
	assign tick = event_in && !clr && ((cnt_reg & mask) == mask);

	always_ff @(posedge clk) begin
		if (!rst_n || clr) begin
			cnt_reg <= '0;
		end else if (event_in) begin
			cnt_reg <= tick ? '0 : cnt_reg + 1'b1;
		end
	end
endmodule

//--- core/tovi_timer.sv
// Free-running up-counter with software load and wrap detection.
// Assumes inc is a one-cycle pulse per count.
`timescale 1ns/1ps
module tovi_timer #(
	parameter int CNT_W = 8                 // Counter width
) (
	input  wire logic             clk,     // Core clock
	input  wire logic             rst_n,   // Synchronous reset, low
	input  wire logic             load,    // Software write
	input  wire logic [CNT_W-1:0] load_val,// Value written
	input  wire logic             inc,     // Count one
	output logic      [CNT_W-1:0] count,   // Current count
	output logic                  wrap     // Max to zero this cycle
);
	import tovi_pkg::*;

	if (CNT_W != 8) begin : g_chk
		$error("tovi_timer: register map is 8 bits wide");
	end

	assign wrap = inc && !load && (count == {CNT_W{1'b1}});

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			count <= RST_TIMER_COUNT;
		end else if (load) begin
			count <= load_val;
		end else if (inc) begin
			count <= count + 1'b1;
		end
	end
endmodule

//--- core/tovi_top.sv
// Timer overflow interrupt block with APB register access.
// Assumes synchronous inputs and a single core clock.
//
// What this block does
// - Prescaler assignment switches live, no reset needed
// - Count wrap to zero sets overflow flag
// - Overflow enable clear suppresses the request
// - Timer halts during sleep, never wakes core
// - Unimplemented bits read back as zero
// - Flags set regardless of any enable
// - Global enable gates TIMER_IRQ only, not IRQ, cleared on reset
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
module tovi_top
	import tovi_pkg::*;
(
	input  wire logic                 CLOCK,         // Core clock
	input  wire logic                 RST_N,         // Sync reset
	input  wire logic                 PSEL,          // APB select
	input  wire logic                 PENABLE,       // APB enable
	input  wire logic                 PWRITE,        // APB direction
	input  wire logic [tovi_pkg::ADDR_W-1:0] PADDR,  // APB address
	input  wire logic [31:0]          PWDATA,        // APB write data
	input  wire logic [3:0]           PSTRB,         // APB strobes
	input  wire logic                 TIMER_CLK_IN,  // External count
	input  wire logic                 WATCHDOG_TICK_IN, // Wd source
	output logic                      PREADY,        // APB ready
	output logic [31:0]               PRDATA,        // APB read data
	output logic                      PSLVERR,       // APB error
	output logic                      TIMER_IRQ,     // Core request
	output logic                      IRQ,           // Status irq
	output logic                      WATCHDOG_TICK_OUT, // To watchdog
	output logic                      PORT_PULLUP_DISABLE, // Pullups
	output logic [4:0]                PORTA_DIRECTION  // Pin dirs
);
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	typedef enum logic [1:0] {
		TOVI_IDLE,
		TOVI_ANSWER
	} tovi_bus_e;

	tovi_bus_e        bus_state_reg;
	logic [7:0]       intctl_reg;
	logic [7:0]       option_reg;
	logic [4:0]       porta_dir_reg;
	logic [7:0]       ctrl_reg;
	logic [EVT_W-1:0] irq_status_reg;
	logic [EVT_W-1:0] irq_mask_reg;
	logic             ext_clk_reg;
	logic             pready_reg;
	logic             pslverr_reg;
	logic [31:0]      prdata_reg;
	logic             timer_irq_reg;
	logic             irq_reg;
	logic             wd_tick_reg;
	logic             ps_assign_reg;
	logic [31:0]      prdata_next;
	logic             pslverr_next;
	logic [7:0]       timer_count;
	logic             timer_wrap;
	logic             ext_edge;
	logic             count_event;
	logic             ps_event;
	logic             ps_tick;
	logic [3:0]       ps_exp;
	logic             timer_inc;
	logic             to_timer;
	logic             sleeping;
	logic             setup;
	logic             wr_take;
	logic             wr_timer;
	logic             wr_intctl;
	logic             wr_option;
	logic             wr_porta;
	logic             wr_ctrl;
	logic             wr_status;
	logic             wr_mask;
	logic [EVT_W-1:0] evt_set;

	// Word index of an aligned address; misaligned gives no match
	function automatic logic [8:0] reg_index(
		input logic [ADDR_W-1:0] addr
	);
		reg_index = (addr[1:0] == 2'b00) ? {1'b0, addr[9:2]} : 9'h100;
	endfunction

	// True when an address hits the given register
	function automatic logic hit(
		input logic [ADDR_W-1:0] addr,
		input logic [7:0]        idx
	);
		hit = (reg_index(addr) == {1'b0, idx}) && (addr[ADDR_W-1:10] == '0);
	endfunction

	// ----------------------------------------
	// Bus access decode
	// ----------------------------------------
	assign setup   = PSEL && !PENABLE;
	assign wr_take = PSEL && PENABLE && PWRITE && pready_reg && !pslverr_reg
		&& PSTRB[0];

	assign wr_timer  = wr_take && hit(PADDR, IDX_TIMER_COUNT);
	assign wr_intctl = wr_take && hit(PADDR, IDX_INTCTL);
	assign wr_option = wr_take && hit(PADDR, IDX_OPTION);
	assign wr_porta  = wr_take && hit(PADDR, IDX_PORTA_DIR);
	assign wr_ctrl   = wr_take && hit(PADDR, IDX_CTRL);
	assign wr_status = wr_take && hit(PADDR, IDX_IRQ_STATUS);
	assign wr_mask   = wr_take && hit(PADDR, IDX_IRQ_MASK);

	// Narrow registers sit in the low bits; all else reads zero
	always_comb begin
		prdata_next  = RD_ZERO;
		pslverr_next = 1'b0;
		if (hit(PADDR, IDX_TIMER_COUNT)) begin
			prdata_next = {24'h000000, timer_count};
		end else if (hit(PADDR, IDX_INTCTL)) begin
			prdata_next = {24'h000000, intctl_reg};
		end else if (hit(PADDR, IDX_OPTION)) begin
			prdata_next = {24'h000000, option_reg};
		end else if (hit(PADDR, IDX_PORTA_DIR)) begin
			prdata_next = {27'h0000000, porta_dir_reg};
		end else if (hit(PADDR, IDX_CTRL)) begin
			prdata_next = {24'h000000, ctrl_reg};
		end else if (hit(PADDR, IDX_IRQ_STATUS)) begin
			prdata_next = {30'h00000000, irq_status_reg};
		end else if (hit(PADDR, IDX_IRQ_MASK)) begin
			prdata_next = {30'h00000000, irq_mask_reg};
		end else begin
			pslverr_next = 1'b1;
		end
		if (PWRITE) begin
			prdata_next = RD_ZERO;
		end
	end

	// ----------------------------------------
	// APB slave: answer one cycle after setup
	// ----------------------------------------
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			bus_state_reg <= TOVI_IDLE;
			pready_reg    <= 1'b0;
			pslverr_reg   <= 1'b0;
			prdata_reg    <= RD_ZERO;
		end else begin
			case (bus_state_reg)
				TOVI_IDLE: begin
					if (setup) begin
						bus_state_reg <= TOVI_ANSWER;
						pready_reg    <= 1'b1;
						pslverr_reg   <= pslverr_next;
						prdata_reg    <= prdata_next;
					end
				end
				TOVI_ANSWER: begin
					bus_state_reg <= TOVI_IDLE;
					pready_reg    <= 1'b0;
					pslverr_reg   <= 1'b0;
					prdata_reg    <= RD_ZERO;
				end
				default: begin
					bus_state_reg <= TOVI_IDLE;
					pready_reg    <= 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			option_reg <= RST_OPTION;
		end else if (wr_option) begin
			option_reg <= PWDATA[7:0];
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			porta_dir_reg <= RST_PORTA_DIR;
		end else if (wr_porta) begin
			porta_dir_reg <= PWDATA[4:0];
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			ctrl_reg <= RST_CTRL;
		end else if (wr_ctrl) begin
			ctrl_reg <= {7'h00, PWDATA[BIT_SLEEP]};
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			irq_mask_reg <= '0;
		end else if (wr_mask) begin
			irq_mask_reg <= PWDATA[EVT_W-1:0];
		end
	end

	// ----------------------------------------
	// Count source and prescaler routing
	// ----------------------------------------
	assign sleeping = ctrl_reg[BIT_SLEEP];
	assign to_timer = !option_reg[BIT_PS_ASSIGN];

	// Edge on the external input, polarity from the option register
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			ext_clk_reg <= 1'b0;
		end else begin
			ext_clk_reg <= TIMER_CLK_IN;
		end
	end

	assign ext_edge = option_reg[BIT_SRC_EDGE] ? (ext_clk_reg && !TIMER_CLK_IN)
		: (!ext_clk_reg && TIMER_CLK_IN);

	// Sleep freezes every timer source so no wrap can occur
	assign count_event = !sleeping && (option_reg[BIT_CLK_SOURCE] ? ext_edge
		: 1'b1);

	// Timer side divides by 2**(rate+1), watchdog side by 2**rate
	assign ps_event = to_timer ? count_event : WATCHDOG_TICK_IN;
	assign ps_exp   = to_timer ? {1'b0, option_reg[PS_RATE_MSB:0]} + 4'h1
		: {1'b0, option_reg[PS_RATE_MSB:0]};
	assign timer_inc = to_timer ? ps_tick : count_event;

	// Track the assignment so a switch restarts the division cleanly
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			ps_assign_reg <= RST_OPTION[BIT_PS_ASSIGN];
		end else begin
			ps_assign_reg <= option_reg[BIT_PS_ASSIGN];
		end
	end

	// A timer write also clears a timer-owned prescaler
	tovi_prescaler #(
		.CNT_W    (8)
	) u_prescaler (
		.clk      (CLOCK),
		.rst_n    (RST_N),
		.clr      ((ps_assign_reg != option_reg[BIT_PS_ASSIGN])
			|| (wr_timer && to_timer)),
		.event_in (ps_event),
		.rate_exp (ps_exp),
		.tick     (ps_tick)
	);

	// Watchdog path keeps running while asleep; it is not gated
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			wd_tick_reg <= 1'b0;
		end else begin
			wd_tick_reg <= to_timer ? WATCHDOG_TICK_IN : ps_tick;
		end
	end

	// ----------------------------------------
	// Timer count
	// ----------------------------------------
	tovi_timer #(
		.CNT_W    (8)
	) u_timer (
		.clk      (CLOCK),
		.rst_n    (RST_N),
		.load     (wr_timer),
		.load_val (PWDATA[7:0]),
		.inc      (timer_inc),
		.count    (timer_count),
		.wrap     (timer_wrap)
	);

	// ----------------------------------------
	// Interrupt control register
	// ----------------------------------------
	// Only the overflow flag is set by hardware; the set beats a
	// software clear in the same cycle so no wrap is lost.
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			intctl_reg <= RST_INTCTL;
		end else begin
			if (wr_intctl) begin
				intctl_reg <= PWDATA[7:0];
			end
			if (timer_wrap) begin
				intctl_reg[BIT_TOVF_FLAG] <= 1'b1;
			end
		end
	end

	// Request to the core, registered to keep outputs glitch free
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			timer_irq_reg <= 1'b0;
		end else begin
			timer_irq_reg <= intctl_reg[BIT_TOVF_FLAG]
				&& intctl_reg[BIT_TOVF_EN]
				&& intctl_reg[BIT_GLOBAL_EN];
		end
	end

	// ----------------------------------------
	// Sticky status and its interrupt line
	// ----------------------------------------
	always_comb begin
		evt_set = '0;
		evt_set[EVT_OVERFLOW] = timer_wrap;
		evt_set[EVT_WD_TICK]  = !to_timer && ps_tick;
	end

	// Write one to clear; a new event in the same cycle wins
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			irq_status_reg <= '0;
		end else if (wr_status) begin
			irq_status_reg <= (irq_status_reg & ~PWDATA[EVT_W-1:0]) | evt_set;
		end else begin
			irq_status_reg <= irq_status_reg | evt_set;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= |(irq_status_reg & irq_mask_reg);
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign PREADY              = pready_reg;
	assign PRDATA              = prdata_reg;
	assign PSLVERR             = pslverr_reg;
	assign TIMER_IRQ           = timer_irq_reg;
	assign IRQ                 = irq_reg;
	assign WATCHDOG_TICK_OUT   = wd_tick_reg;
	assign PORT_PULLUP_DISABLE = option_reg[BIT_PULLUP_DIS];
	assign PORTA_DIRECTION     = porta_dir_reg;
endmodule

//--- verification/tovi_checker.sv
// Port-level assertions for the timer overflow interrupt block.
// Assumes one clock and a synchronous active-low reset; bound below.
`timescale 1ns/1ps
module tovi_checker
	import tovi_pkg::*;
(
	input wire logic              CLOCK,               // Clock
	input wire logic              RST_N,               // Reset
	input wire logic              PSEL,                // Select
	input wire logic              PENABLE,             // Enable
	input wire logic              PWRITE,              // Direction
	input wire logic [ADDR_W-1:0] PADDR,               // Address
	input wire logic [31:0]       PWDATA,              // Write data
	input wire logic [3:0]        PSTRB,               // Strobes
	input wire logic              TIMER_CLK_IN,        // Count input
	input wire logic              WATCHDOG_TICK_IN,    // Wd source
	input wire logic              PREADY,              // Ready
	input wire logic [31:0]       PRDATA,              // Read data
	input wire logic              PSLVERR,             // Error
	input wire logic              TIMER_IRQ,           // Core request
	input wire logic              IRQ,                 // Status irq
	input wire logic              WATCHDOG_TICK_OUT,   // To watchdog
	input wire logic              PORT_PULLUP_DISABLE, // Pullups
	input wire logic [4:0]        PORTA_DIRECTION      // Pin dirs
);
	logic g_sh;
	logic e_sh;
	logic psa_sh;
	logic pu_sh;
	logic wr;
	assign wr = PSEL && PENABLE && PREADY && PWRITE && PSTRB[0];
	// --------------------------------
	// Shadows of gate bits, written at the same edge as the design
	// --------------------------------
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			g_sh   <= 1'b0;
			e_sh   <= 1'b0;
			psa_sh <= 1'b1;
			pu_sh  <= 1'b1;
		end else begin
			if (wr && PADDR == 12'h02C) begin
				g_sh <= PWDATA[BIT_GLOBAL_EN];
				e_sh <= PWDATA[BIT_TOVF_EN];
			end
			if (wr && PADDR == 12'h204) begin
				psa_sh <= PWDATA[BIT_PS_ASSIGN];
				pu_sh  <= PWDATA[BIT_PULLUP_DIS];
			end
		end
	end
	// --------------------------------
	// Assertions
	// --------------------------------
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RST_N);
	a_ready_one_cycle: assert property (PSEL && !PENABLE |=> PREADY ##1 !PREADY)
		else $error("ready not a single cycle after setup");
	a_bad_addr_err: assert property (PREADY && !(PADDR inside {12'h004, 12'h02C,
		12'h204, 12'h214, 12'h300, 12'h304, 12'h308}) |-> PSLVERR && PRDATA == 32'h0)
		else $error("unmapped access not refused");
	a_unused_bits_zero: assert property (PREADY && !PWRITE |-> PRDATA[31:8] == 24'h0 &&
		(PADDR != 12'h214 || PRDATA[7:5] == 3'h0))
		else $error("unimplemented read bits not zero");
	a_global_gate: assert property (!g_sh |=> !TIMER_IRQ)
		else $error("request with global enable clear");
	a_enable_gate: assert property (!e_sh |=> !TIMER_IRQ)
		else $error("request with overflow enable clear");
	a_irq_cause: assert property ($rose(TIMER_IRQ) |-> $past(g_sh) && $past(e_sh))
		else $error("request rose without both enables");
	a_wd_raw_path: assert property (!psa_sh |=> WATCHDOG_TICK_OUT == $past(WATCHDOG_TICK_IN))
		else $error("watchdog tick not passed straight through");
	a_pullup_follow: assert property (PORT_PULLUP_DISABLE == pu_sh)
		else $error("pullup output differs from option bit");
	c_timer_irq: cover property ($rose(TIMER_IRQ));
	c_status_irq: cover property ($rose(IRQ));
	c_refused: cover property (PREADY && PSLVERR);
endmodule

bind tovi_top tovi_checker i_tovi_checker (.CLOCK(CLOCK), .RST_N(RST_N), .PSEL(PSEL),
	.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB),
	.TIMER_CLK_IN(TIMER_CLK_IN), .WATCHDOG_TICK_IN(WATCHDOG_TICK_IN), .PREADY(PREADY),
	.PRDATA(PRDATA), .PSLVERR(PSLVERR), .TIMER_IRQ(TIMER_IRQ), .IRQ(IRQ),
	.WATCHDOG_TICK_OUT(WATCHDOG_TICK_OUT), .PORT_PULLUP_DISABLE(PORT_PULLUP_DISABLE),
	.PORTA_DIRECTION(PORTA_DIRECTION));

//--- verification/tovi_top_tb.sv
// Self-checking bench for the timer overflow interrupt block.
// Assumes the checker file is compiled alongside and binds itself.
`timescale 1ns/1ps
module tovi_top_tb;
	import tovi_pkg::*;
	logic              CLOCK, RST_N, PSEL, PENABLE, PWRITE;
	logic [ADDR_W-1:0] PADDR;
	logic [31:0]       PWDATA, PRDATA;
	logic [3:0]        PSTRB;
	logic              TIMER_CLK_IN, WATCHDOG_TICK_IN, PREADY, PSLVERR, TIMER_IRQ, IRQ;
	logic              WATCHDOG_TICK_OUT, PORT_PULLUP_DISABLE;
	logic [4:0]        PORTA_DIRECTION;
	int                error_cnt = 0;
	int                checks = 0;
	int                cyc = 0;
	logic [31:0]       rd;
	logic              er;

	tovi_top i_tovi_top (.CLOCK(CLOCK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
		.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB),
		.TIMER_CLK_IN(TIMER_CLK_IN), .WATCHDOG_TICK_IN(WATCHDOG_TICK_IN), .PREADY(PREADY),
		.PRDATA(PRDATA), .PSLVERR(PSLVERR), .TIMER_IRQ(TIMER_IRQ), .IRQ(IRQ),
		.WATCHDOG_TICK_OUT(WATCHDOG_TICK_OUT), .PORT_PULLUP_DISABLE(PORT_PULLUP_DISABLE),
		.PORTA_DIRECTION(PORTA_DIRECTION));
	// --------------------------------
	// Clock, timeout and shared tasks
	// --------------------------------
	initial begin
		CLOCK = 1'b0;
		forever #5 CLOCK = ~CLOCK;
	end
	always @(posedge CLOCK) begin
		cyc++;
		if (cyc > 20000) begin
			error_cnt++;
			give_verdict();
		end
	end
	task automatic give_verdict();
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Holds the request until ready is seen high, then idles one cycle
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		PSEL <= 1'b1; PENABLE <= 1'b0; PWRITE <= w; PADDR <= a; PWDATA <= d;
		@(posedge CLOCK);
		PENABLE <= 1'b1;
		do begin
			@(posedge CLOCK);
		end while (PREADY !== 1'b1);
		rd = PRDATA;
		er = PSLVERR;
		PSEL <= 1'b0; PENABLE <= 1'b0;
		@(posedge CLOCK);
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge CLOCK);
	endtask
	task automatic wd_pulse(output int cnt);
		cnt = 0;
		WATCHDOG_TICK_IN <= 1'b1;
		@(posedge CLOCK);
		WATCHDOG_TICK_IN <= 1'b0;
		repeat (5) begin
			@(posedge CLOCK);
			if (WATCHDOG_TICK_OUT === 1'b1) cnt++;
		end
	endtask
	// --------------------------------
	// Scenarios
	// --------------------------------
	task automatic t_reset_values();
		rdc(12'h02C, 32'h0);
		rdc(12'h204, 32'hFF);
		rdc(12'h214, 32'h1F);
		rdc(12'h304, 32'h0);
		chk(PORT_PULLUP_DISABLE, 1'b1);
		apb(1'b1, 12'h214, 32'hFFFF_FFE0);
		rdc(12'h214, 32'h0);
		chk(PORTA_DIRECTION, 5'h0);
		PSTRB <= 4'h0;
		apb(1'b1, 12'h214, 32'h0000_001F);
		PSTRB <= 4'hF;
		rdc(12'h214, 32'h0);
		chk(PORTA_DIRECTION, 5'h0);
		rdc(12'h010, 32'h0);
		chk(er, 1'b1);
	endtask
	task automatic t_wrap_flag();
		apb(1'b1, 12'h204, 32'h08);
		apb(1'b1, 12'h004, 32'hFD);
		wait_cyc(10);
		rdc(12'h02C, 32'h04);
		chk(TIMER_IRQ, 1'b0);
	endtask
	task automatic t_gating();
		apb(1'b1, 12'h02C, 32'h24);
		wait_cyc(3);
		chk(TIMER_IRQ, 1'b0);
		apb(1'b1, 12'h02C, 32'hA4);
		wait_cyc(3);
		chk(TIMER_IRQ, 1'b1);
		wait_cyc(5);
		rdc(12'h02C, 32'hA4);
		apb(1'b1, 12'h02C, 32'h84);
		wait_cyc(3);
		chk(TIMER_IRQ, 1'b0);
		apb(1'b1, 12'h02C, 32'h80);
		rdc(12'h02C, 32'h80);
	endtask
	task automatic t_status_irq();
		chk(IRQ, 1'b0);
		apb(1'b1, 12'h308, 32'h1);
		wait_cyc(2);
		chk(IRQ, 1'b1);
		apb(1'b1, 12'h304, 32'h1);
		wait_cyc(2);
		chk(IRQ, 1'b0);
		rdc(12'h304, 32'h0);
	endtask
	task automatic t_sleep();
		apb(1'b1, 12'h02C, 32'h00);
		apb(1'b1, 12'h300, 32'h1);
		apb(1'b1, 12'h004, 32'hFE);
		wait_cyc(20);
		rdc(12'h004, 32'hFE);
		rdc(12'h02C, 32'h00);
		apb(1'b1, 12'h300, 32'h0);
		wait_cyc(10);
		rdc(12'h02C, 32'h04);
	endtask
	task automatic t_prescaler_switch();
		int cnt;
		apb(1'b1, 12'h204, 32'h00);
		wd_pulse(cnt);
		chk(cnt, 1);
		apb(1'b1, 12'h004, 32'h00);
		wait_cyc(10);
		rdc(12'h004, 32'h05);
		// Clear timer and prescaler before handing it to the watchdog
		apb(1'b1, 12'h004, 32'h00);
		apb(1'b1, 12'h204, 32'h28);
		wd_pulse(cnt);
		chk(cnt, 1);
		rdc(12'h304, 32'h3);
		apb(1'b1, 12'h004, 32'h00);
		repeat (5) begin
			TIMER_CLK_IN <= 1'b1;
			wait_cyc(2);
			TIMER_CLK_IN <= 1'b0;
			wait_cyc(2);
		end
		rdc(12'h004, 32'h05);
		chk(PORT_PULLUP_DISABLE, 1'b0);
	endtask
	task automatic t_mid_reset();
		apb(1'b1, 12'h02C, 32'hA4);
		wait_cyc(2);
		chk(TIMER_IRQ, 1'b1);
		RST_N <= 1'b0;
		wait_cyc(2);
		RST_N <= 1'b1;
		@(posedge CLOCK);
		chk(TIMER_IRQ, 1'b0);
		rdc(12'h02C, 32'h0);
		rdc(12'h204, 32'hFF);
		chk(PORT_PULLUP_DISABLE, 1'b1);
	endtask
	// --------------------------------
	// Main sequence
	// --------------------------------
	initial begin
		RST_N = 1'b0; PSEL = 1'b0; PENABLE = 1'b0; PWRITE = 1'b0; PADDR = '0;
		PWDATA = '0; PSTRB = 4'hF; TIMER_CLK_IN = 1'b0; WATCHDOG_TICK_IN = 1'b0;
		repeat (12) @(posedge CLOCK);
		RST_N <= 1'b1;
		@(posedge CLOCK);
		t_reset_values();
		t_wrap_flag();
		t_gating();
		t_status_irq();
		t_sleep();
		t_prescaler_switch();
		t_mid_reset();
		give_verdict();
	end
endmodule
